// >>> src/psq_sequencer.sv
`timescale 1ns/1ps
// Notes on behaviour
// - edge mode: wake level alone never powers up
// - edge mode rising edge powers up; forward wake
// - power-up reload restores level-sensitive wake
// - watchdog holds in power-down mode
// - watchdog runs after power-up; kick gives active
// - watchdog limit: error, clear system-on, power-down
// - each watchdog error decrements retry counter, stopping at zero
// - retry reaching zero activates freeze
// - watchdog power-down with wake held restarts
// - freeze keeps power-down despite wake level
// - level-mode wake release reloads retry, clears freeze
// - power-up only after wake debounce time
// - warning threshold sets event, unmasked asserts irq
// - cleared warning releases irq if nothing pending
// - critical threshold sets sticky flag, shuts down
// - thermal shut-down ordered, ends in reset mode
// - thermal reset reloads retry, keeps critical flag
// - reset mode held while critical, then cold boot
// - por threshold: instant reset, always-on off
// - system-on clear after power-up ends in power-down mode
// - supply steps spaced two milliseconds
// - release core reset, power request enables supplies
// - power-down asserts reset, supplies off reversed
module psq_sequencer
  import psq_pkg::*;
#(
  parameter int unsigned       N_SUPPLY  = NUM_SUPPLY,
  parameter int unsigned       STEP_CYC  = STEP_CYCLES,
  parameter int unsigned       DB_CYC    = DEBOUNCE_CYCLES,
  parameter int unsigned       WD_CYC    = WD_CYCLES,
  parameter logic [RETRY_W-1:0] RETRY_INIT = RETRY_RELOAD
) (
  // clock and reset
  input  wire logic                clk,
  input  wire logic                reset_n,
  // host and accessory pins
  input  wire logic                accessoryWakeInput,
  input  wire logic                hostPowerRequestPin,
  output logic                     wakeForwardOut,
  output logic                     hostCoreResetOut_n,
  // temperature comparators
  input  wire logic                tempOverWarn,
  input  wire logic                tempOverCrit,
  input  wire logic                tempOverPor,
  // software controls and status
  input  wire psq_pkg::psq_ctrl_t  ctrl,
  output psq_pkg::psq_status_t     status,
  output logic                     thermalCriticalFlag,
  output logic                     interruptOut_n,
  // regulator enables
  output logic [N_SUPPLY-1:0]      supplyEnable,
  output logic                     alwaysOnRegulatorEnable
);
  import psq_pkg::*;

  // ---------------------------------------------------------------
  // local widths and helpers
  // ---------------------------------------------------------------
  localparam int SW = $clog2(STEP_CYC + 1);
  localparam int WW = $clog2(WD_CYC + 1);
  localparam int NW = $clog2(N_SUPPLY + 1);

  // thermometer mask of the lowest n supplies
  function automatic logic [N_SUPPLY-1:0] fill(input logic [NW-1:0] n);
    logic [N_SUPPLY-1:0] m;
    m = '0;
    for (int i = 0; i < N_SUPPLY; i++) begin
      m[i] = (NW'(i) < n);
    end
    return m;
  endfunction : fill

  // ---------------------------------------------------------------
  // filtered inputs
  // ---------------------------------------------------------------
  logic wakeLevel;      // debounced wake level
  logic wakeRise;       // debounced wake rising edge
  logic wakeFall;       // debounced wake falling edge
  logic powerReq;       // debounced host power request
  logic warnLevel;      // synchronised warning comparator
  logic warnRise;       // warning threshold crossed
  logic critLevel;      // synchronised critical comparator
  logic porLevel;       // synchronised por comparator

  // wake input with debounce
  psq_input_filter #(.DB_CYCLES(DB_CYC)) u_wake (
    .clk     (clk),
    .reset_n (reset_n),
    .pinIn   (accessoryWakeInput),
    .level   (wakeLevel),
    .rise    (wakeRise),
    .fall    (wakeFall)
  );

  // host power request with debounce
  psq_input_filter #(.DB_CYCLES(DB_CYC)) u_preq (
    .clk     (clk),
    .reset_n (reset_n),
    .pinIn   (hostPowerRequestPin),
    .level   (powerReq),
    .rise    (),
    .fall    ()
  );

  // temperature comparators, synchronised only
  psq_input_filter #(.DB_CYCLES(1)) u_warn (
    .clk     (clk),
    .reset_n (reset_n),
    .pinIn   (tempOverWarn),
    .level   (warnLevel),
    .rise    (warnRise),
    .fall    ()
  );

  psq_input_filter #(.DB_CYCLES(1)) u_crit (
    .clk     (clk),
    .reset_n (reset_n),
    .pinIn   (tempOverCrit),
    .level   (critLevel),
    .rise    (),
    .fall    ()
  );

  psq_input_filter #(.DB_CYCLES(1)) u_por (
    .clk     (clk),
    .reset_n (reset_n),
    .pinIn   (tempOverPor),
    .level   (porLevel),
    .rise    (),
    .fall    ()
  );

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  psq_mode_t           mode;          // operating mode
  logic [NW-1:0]       supplyCount;   // supplies now enabled
  logic [SW-1:0]       stepTimer;     // spacing between steps
  logic [WW-1:0]       wdCount;       // watchdog counter
  logic [RETRY_W-1:0]  retryCount;    // remaining retries
  logic                freeze;        // power-up blocked
  logic                wakeEdgeMode;  // wake input edge detect
  logic                systemOn;      // system-on control
  logic                watchdogError; // last fault was watchdog
  logic                pdToReset;     // shut-down ends in reset
  logic                tempWarnEvent; // sticky warning event

  // decoded conditions
  logic stepDone;   // step interval has elapsed
  logic wdExpire;   // watchdog reached its maximum
  logic running;    // watchdog is counting
  logic wakeStart;  // wake asks for a power-up
  logic critTrip;   // critical fault outside reset and thermal shut-down

  assign stepDone = (stepTimer == SW'(STEP_CYC - 1));
  assign running  = (mode == PSQ_PU_DONE) || (mode == PSQ_ACTIVE);
  assign wdExpire = running && (wdCount == WW'(WD_CYC - 1));
  assign critTrip = critLevel && (mode != PSQ_RESET)
                    && !(mode == PSQ_PD_SEQ && pdToReset);
  // edge mode ignores the level; level mode honours freeze
  assign wakeStart = wakeEdgeMode ? wakeRise
                                  : (wakeLevel && !freeze);

  // ---------------------------------------------------------------
  // mode sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      mode      <= PSQ_RESET;
      pdToReset <= 1'b0;
    end else if (porLevel) begin
      mode      <= PSQ_RESET;
      pdToReset <= 1'b0;
    end else if (critTrip) begin
      mode      <= PSQ_PD_SEQ;
      pdToReset <= 1'b1;
    end else begin
      unique case (mode)
        PSQ_RESET: begin
          // leave only once the die has cooled
          if (!critLevel) begin
            mode <= PSQ_POWERDOWN;
          end
        end
        PSQ_POWERDOWN: begin
          if (wakeStart) begin
            mode <= PSQ_PU_CORE;
          end
        end
        PSQ_PU_CORE: begin
          // second part waits for the host request
          if (powerReq) begin
            mode <= PSQ_PU_SUPPLY;
          end
        end
        PSQ_PU_SUPPLY: begin
          if (stepDone && supplyCount == NW'(N_SUPPLY)) begin
            mode <= PSQ_PU_DONE;
          end
        end
        PSQ_PU_DONE: begin
          if (wdExpire || ctrl.systemOnClear) begin
            mode      <= PSQ_PD_SEQ;
            pdToReset <= 1'b0;
          end else if (ctrl.watchdogKick) begin
            mode <= PSQ_ACTIVE;
          end
        end
        PSQ_ACTIVE: begin
          if (wdExpire || ctrl.systemOnClear) begin
            mode      <= PSQ_PD_SEQ;
            pdToReset <= 1'b0;
          end
        end
        PSQ_PD_SEQ: begin
          // finish after the last supply is off
          if (stepDone && supplyCount == '0) begin
            mode <= pdToReset ? PSQ_RESET
                              : PSQ_POWERDOWN;
          end
        end
        default: mode <= PSQ_RESET;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // supply stepping
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!reset_n || porLevel) begin
      stepTimer   <= '0;
      supplyCount <= '0;
    end else if (mode == PSQ_PU_SUPPLY || mode == PSQ_PD_SEQ) begin
      // fixed interval between consecutive steps
      if (stepDone) begin
        stepTimer <= '0;
        if (mode == PSQ_PU_SUPPLY && supplyCount != NW'(N_SUPPLY)) begin
          supplyCount <= supplyCount + NW'(1);
        end else if (mode == PSQ_PD_SEQ && supplyCount != '0) begin
          supplyCount <= supplyCount - NW'(1);
        end
      end else begin
        stepTimer <= stepTimer + SW'(1);
      end
    end else begin
      stepTimer <= '0;
    end
  end

  // enables follow the count, so off order is reversed
  always_ff @(posedge clk) begin
    if (!reset_n || porLevel) begin
      supplyEnable <= '0;
    end else begin
      supplyEnable <= fill(supplyCount);
    end
  end

  // ---------------------------------------------------------------
  // watchdog
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      wdCount <= '0;
    end else if (!running || ctrl.watchdogKick || wdExpire) begin
      wdCount <= '0;
    end else begin
      wdCount <= wdCount + WW'(1);
    end
  end

  // watchdog error flag, cleared by the first kick after power-up
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      watchdogError <= 1'b0;
    end else if (wdExpire) begin
      watchdogError <= 1'b1;
    end else if (mode == PSQ_PU_DONE && ctrl.watchdogKick) begin
      watchdogError <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // retry counter and freeze
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      retryCount <= RETRY_INIT;
      freeze     <= 1'b0;
    end else if (wdExpire) begin
      // decrement wins over a wake release in the same cycle
      if (retryCount != '0) begin
        retryCount <= retryCount - RETRY_W'(1);
      end
      if (retryCount <= RETRY_W'(1)) begin
        freeze <= 1'b1;
      end
    end else if (wakeFall && !wakeEdgeMode) begin
      retryCount <= RETRY_INIT;
      freeze     <= 1'b0;
    end else if (porLevel || (mode == PSQ_PD_SEQ && pdToReset
                 && stepDone && supplyCount == '0)) begin
      retryCount <= RETRY_INIT;
      freeze     <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // configuration reload and system-on control
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      wakeEdgeMode <= 1'b0;
      systemOn     <= 1'b0;
    end else if (mode == PSQ_POWERDOWN && wakeStart && !porLevel
                 && !critTrip) begin
      wakeEdgeMode <= 1'b0;
      systemOn     <= 1'b1;
    end else begin
      if (ctrl.wakeEdgeSet) begin
        wakeEdgeMode <= 1'b1;
      end
      if (wdExpire || ctrl.systemOnClear || critTrip || porLevel) begin
        systemOn <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // thermal events and interrupt
  // ---------------------------------------------------------------
  // warning event, set wins over clear
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      tempWarnEvent <= 1'b0;
    end else if (warnRise) begin
      tempWarnEvent <= 1'b1;
    end else if (ctrl.tempWarnClear) begin
      tempWarnEvent <= 1'b0;
    end
  end

  // critical flag, sticky across the reset mode
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      thermalCriticalFlag <= 1'b0;
    end else if (critLevel) begin
      thermalCriticalFlag <= 1'b1;
    end else if (ctrl.faultClear) begin
      thermalCriticalFlag <= 1'b0;
    end
  end

  // interrupt low while any unmasked event pends
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      interruptOut_n <= 1'b1;
    end else begin
      interruptOut_n <= !((tempWarnEvent && !ctrl.tempWarnMask)
                          || ctrl.otherEvent);
    end
  end

  // ---------------------------------------------------------------
  // pin and status outputs
  // ---------------------------------------------------------------
  // core reset held except during power-up and running modes
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      hostCoreResetOut_n <= 1'b0;
      wakeForwardOut     <= 1'b0;
    end else begin
      hostCoreResetOut_n <= !porLevel && !critTrip
                            && (mode == PSQ_PU_CORE
                            || mode == PSQ_PU_SUPPLY
                            || running);
      wakeForwardOut     <= wakeLevel;
    end
  end

  // always-on regulator, dropped only by the por threshold
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      alwaysOnRegulatorEnable <= 1'b0;
    end else begin
      alwaysOnRegulatorEnable <= !porLevel;
    end
  end

  // status snapshot for software
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      status <= '{mode: PSQ_RESET, retryCount: RETRY_INIT,
                  default: 1'b0};
    end else begin
      status.mode          <= mode;
      status.systemOn      <= systemOn;
      status.wakeEdgeMode  <= wakeEdgeMode;
      status.watchdogError <= watchdogError;
      status.freeze        <= freeze;
      status.tempWarnEvent <= tempWarnEvent;
      status.retryCount    <= retryCount;
    end
  end

endmodule : psq_sequencer

// >>> include/psq_pkg.sv
// ---------------------------------------------------------------
// sequencer constants and carriers
// ---------------------------------------------------------------
package psq_pkg;

  // clock rate in kHz, 40 MHz
  localparam int unsigned CLK_KHZ = 40000;

  // spacing of supply steps
  localparam int unsigned STEP_TIME_MS = 2;
  localparam int unsigned STEP_CYCLES  = STEP_TIME_MS * CLK_KHZ;

  // input debounce time, plain default
  localparam int unsigned DEBOUNCE_TIME_US = 50;
  localparam int unsigned DEBOUNCE_CYCLES  =
    (DEBOUNCE_TIME_US * CLK_KHZ + 999) / 1000;

  // watchdog limit, one kick period
  localparam int unsigned WD_TIME_MS = 2000;
  localparam int unsigned WD_CYCLES  = WD_TIME_MS * CLK_KHZ;

  // supplies stepped by the sequencer, always-on excluded
  localparam int unsigned NUM_SUPPLY = 6;

  // retry counter width and reload value
  localparam int unsigned RETRY_W      = 4;
  localparam logic [3:0]  RETRY_RELOAD = 4'h3;

  // operating modes, one-hot
  typedef enum logic [6:0] {
    PSQ_RESET     = 7'h01,
    PSQ_POWERDOWN = 7'h02,
    PSQ_PU_CORE   = 7'h04,
    PSQ_PU_SUPPLY = 7'h08,
    PSQ_PU_DONE   = 7'h10,
    PSQ_ACTIVE    = 7'h20,
    PSQ_PD_SEQ    = 7'h40
  } psq_mode_t;

  // software side controls, decoded from the serial bus
  typedef struct packed {
    logic wakeEdgeSet;    // pulse: wake input to edge detection
    logic systemOnClear;  // pulse: clear system-on control
    logic watchdogKick;   // pulse: keep-alive write
    logic tempWarnClear;  // pulse: clear thermal warning event
    logic tempWarnMask;   // level: mask thermal warning event
    logic faultClear;     // pulse: clear thermal critical flag
    logic otherEvent;     // level: another event still pending
  } psq_ctrl_t;

  // status shown to software
  typedef struct packed {
    psq_mode_t       mode;
    logic            systemOn;
    logic            wakeEdgeMode;
    logic            watchdogError;
    logic            freeze;
    logic            tempWarnEvent;
    logic [3:0]      retryCount;
  } psq_status_t;

endpackage : psq_pkg

// >>> src/psq_input_filter.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------
// pin synchroniser and debounce filter
// ---------------------------------------------------------------
module psq_input_filter #(
  parameter int unsigned DB_CYCLES = 2000
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic reset_n,
  // raw pin
  input  wire logic pinIn,
  // filtered level and its edges
  output logic      level,
  output logic      rise,
  output logic      fall
);
  import psq_pkg::*;

  localparam int CW = $clog2(DB_CYCLES + 1);

  logic          sync1;   // first stage, read by sync2 only
  logic          sync2;   // second stage
  logic          sync3;   // third stage
  logic [CW-1:0] dbCount; // cycles the new level has held

  // three-stage synchroniser
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      sync1 <= 1'b0;
      sync2 <= 1'b0;
      sync3 <= 1'b0;
    end else begin
      sync1 <= pinIn;
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  // a change counts once stages two and three agree and hold
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      dbCount <= '0;
      level   <= 1'b0;
      rise    <= 1'b0;
      fall    <= 1'b0;
    end else begin
      rise <= 1'b0;
      fall <= 1'b0;
      if (sync2 != sync3 || sync3 == level) begin
        dbCount <= '0;  // unstable or unchanged
      end else if (dbCount >= CW'(DB_CYCLES - 1)) begin
        dbCount <= '0;  // new level accepted
        level   <= sync3;
        rise    <= sync3;
        fall    <= ~sync3;
      end else begin
        dbCount <= dbCount + CW'(1);
      end
    end
  end

endmodule : psq_input_filter

// >>> sim/psq_seq_properties.sv
`timescale 1ns/1ps
// ------------------------------------------
// port checker for the sequencer
// ------------------------------------------
module psq_seq_properties
  import psq_pkg::*;
#(
  parameter int unsigned       STEP_CYC   = 8,
  parameter int unsigned       N_SUPPLY   = 6,
  parameter logic [3:0]        RETRY_INIT = 4'h3
) (
  // clock and reset
  input wire logic                clk,
  input wire logic                reset_n,
  // watched signals
  input wire logic                tempOverPor,
  input wire psq_pkg::psq_ctrl_t  ctrl,
  input wire psq_pkg::psq_status_t status,
  input wire logic                thermalCriticalFlag,
  input wire logic                interruptOut_n,
  input wire logic                hostCoreResetOut_n,
  input wire logic [N_SUPPLY-1:0] supplyEnable,
  input wire logic                alwaysOnRegulatorEnable
);
  int unsigned gap;  // cycles since last enable change
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  // count quiet cycles between supply steps
  always_ff @(posedge clk) begin
    if (!reset_n || $changed(supplyEnable)) gap <= 0;
    else gap <= gap + 1;
  end
  sequence por_held;
    tempOverPor [*6];
  endsequence
  thermo_shape_a: assert property (
    ((supplyEnable + 1'b1) & supplyEnable) == '0)
    else $error("supply enables not thermometer");
  step_gap_a: assert property (
    $changed(supplyEnable) && $past(supplyEnable) != '0
    && supplyEnable != '0 |-> gap >= STEP_CYC - 1)
    else $error("supply step too early");
  active_core_a: assert property (
    status.mode == PSQ_ACTIVE |-> $past(hostCoreResetOut_n))
    else $error("core reset low while active");
  down_quiet_a: assert property (
    status.mode == PSQ_POWERDOWN |-> supplyEnable == '0
    && !hostCoreResetOut_n)
    else $error("power-down mode not quiet");
  retry_step_a: assert property (
    $changed(status.retryCount) && status.retryCount != RETRY_INIT
    |-> status.retryCount == $past(status.retryCount) - 4'h1
    && !status.systemOn)
    else $error("retry change wrong");
  freeze_zero_a: assert property (
    status.retryCount == 4'h0 |-> status.freeze)
    else $error("freeze missing at zero retries");
  active_entry_a: assert property (
    $rose(status.mode == PSQ_ACTIVE) |-> $past(status.mode) == PSQ_PU_DONE)
    else $error("active entered not from done");
  freeze_hold_a: assert property (
    status.freeze && status.mode == PSQ_POWERDOWN
    && alwaysOnRegulatorEnable && !thermalCriticalFlag
    |=> status.mode == PSQ_POWERDOWN)
    else $error("frozen device left power-down");
  other_irq_a: assert property (
    ctrl.otherEvent [*2] |-> !interruptOut_n)
    else $error("irq released with event pending");
  por_off_a: assert property (
    por_held |-> !alwaysOnRegulatorEnable && supplyEnable == '0)
    else $error("por left a regulator on");
  crit_down_a: assert property (
    $rose(thermalCriticalFlag) |-> ##[0:3] status.mode == PSQ_PD_SEQ)
    else $error("critical flag without shut-down");
endmodule : psq_seq_properties

bind psq_sequencer psq_seq_properties #(.STEP_CYC(STEP_CYC),
  .N_SUPPLY(N_SUPPLY), .RETRY_INIT(RETRY_INIT)) psq_seq_properties_inst (
  .clk, .reset_n, .tempOverPor, .ctrl, .status, .thermalCriticalFlag,
  .interruptOut_n, .hostCoreResetOut_n, .supplyEnable,
  .alwaysOnRegulatorEnable);

// >>> sim/psq_host_model.sv
`timescale 1ns/1ps
// ------------------------------------------
// host processor: power request and kicks
// ------------------------------------------
module psq_host_model
  import psq_pkg::*;
(
  // clock
  input wire logic                 clk,
  // from the sequencer
  input wire logic                 hostCoreResetOut_n,
  input wire psq_pkg::psq_status_t status,
  // bench knobs
  input wire logic                 kickOn,
  input wire logic [3:0]           lag,
  // to the sequencer
  output logic                     powerReq,
  output logic                     kick
);
  int unsigned waitCnt;  // request delay count
  logic [3:0]  tick;     // kick period in active mode
  initial begin
    powerReq = 1'b0;
    kick = 1'b0;
    waitCnt = 0;
    tick = 4'h0;
  end
  // request drops with core reset, rises after lag
  always @(negedge clk) begin
    tick <= tick + 4'h1;
    if (!hostCoreResetOut_n) begin
      powerReq <= 1'b0;
      waitCnt <= 0;
    end else if (waitCnt < lag) waitCnt <= waitCnt + 1;
    else powerReq <= 1'b1;
    kick <= kickOn && !kick && (status.mode == PSQ_PU_DONE ||
      (status.mode == PSQ_ACTIVE && tick == 4'h0));
  end
endmodule : psq_host_model

// >>> sim/psq_sequencer_tb.sv
`timescale 1ns/1ps
module psq_sequencer_tb;
  import psq_pkg::*;
  // ------------------------------------------
  // signals
  // ------------------------------------------
  logic        clk, reset_n, wake, warn, crit, por, kickOn;
  logic        wakeFwd, coreRst_n, critFlag, irq_n, aon, preq, kick;
  logic [3:0]  lag;
  logic [5:0]  sup;
  psq_ctrl_t   ctrl, sw;
  psq_status_t st;
  int unsigned bad_count, cmp_count;
  logic [31:0] rng;
  logic [35:0] q[$];  // kind above, expected value below
  always_comb begin
    ctrl = sw;
    ctrl.watchdogKick = kick;
  end
  psq_sequencer #(.STEP_CYC(8), .WD_CYC(64), .DB_CYC(4)) psq_sequencer_inst (
    .clk(clk), .reset_n(reset_n), .accessoryWakeInput(wake),
    .hostPowerRequestPin(preq), .wakeForwardOut(wakeFwd),
    .hostCoreResetOut_n(coreRst_n), .tempOverWarn(warn),
    .tempOverCrit(crit), .tempOverPor(por), .ctrl(ctrl), .status(st),
    .thermalCriticalFlag(critFlag), .interruptOut_n(irq_n),
    .supplyEnable(sup), .alwaysOnRegulatorEnable(aon));
  psq_host_model psq_host_model_inst (.clk(clk),
    .hostCoreResetOut_n(coreRst_n), .status(st), .kickOn(kickOn),
    .lag(lag), .powerReq(preq), .kick(kick));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // ------------------------------------------
  // helpers
  // ------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : xs
  function automatic logic [31:0] obs(input logic [3:0] k);
    case (k)
      4'h0: obs = 32'(st.mode);
      4'h1: obs = 32'(sup);
      4'h2: obs = 32'(coreRst_n);
      4'h3: obs = 32'(wakeFwd);
      4'h4: obs = 32'(st.retryCount);
      4'h5: obs = 32'(st.freeze);
      4'h6: obs = 32'(st.wakeEdgeMode);
      4'h7: obs = 32'(irq_n);
      4'h8: obs = 32'(critFlag);
      4'h9: obs = 32'(aon);
      4'hB: obs = 32'(st.systemOn);
      4'hC: obs = 32'(st.tempWarnEvent);
      default: obs = 32'(st.watchdogError);
    endcase
  endfunction : obs
  task automatic summarize();
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : summarize
  task automatic exp(input logic [3:0] k, input logic [31:0] v);
    q.push_back({k, v});
  endtask : exp
  task automatic cmp(input logic [35:0] e);
    logic [31:0] o;
    o = obs(e[35:32]);
    cmp_count++;
    if (o !== e[31:0]) begin
      bad_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, o, e[31:0]);
    end
  endtask : cmp
  // monitor: every pending note, oldest first, against settled outputs
  always @(negedge clk) begin
    #1;
    while (q.size() > 0) cmp(q.pop_front());
  end
  task automatic idle(input int n);
    repeat (n) @(negedge clk);
  endtask : idle
  task automatic wait_for(input logic [3:0] k, input logic [31:0] v);
    int n;
    n = 0;
    while (obs(k) !== v) begin
      @(negedge clk);
      n++;
      if (n > 3000) begin
        bad_count++;
        summarize();
      end
    end
  endtask : wait_for
  task automatic pulse(input int b);
    sw[b] = 1'b1;
    @(negedge clk);
    sw[b] = 1'b0;
  endtask : pulse
  // ------------------------------------------
  // scenarios
  // ------------------------------------------
  initial begin
    reset_n = 1'b0;
    {wake, warn, crit, por} = 4'h0;
    kickOn = 1'b1;
    sw = '0;
    sw.tempWarnMask = 1'b1;
    bad_count = 0;
    cmp_count = 0;
    rng = 32'hB0572320;
    lag = 4'h2;
    idle(6);
    reset_n = 1'b1;
    wait_for(4'h0, PSQ_POWERDOWN);
    wake = 1'b1;
    wait_for(4'h0, PSQ_ACTIVE);
    exp(4'h3, 32'h1);
    exp(4'h1, 32'h3F);
    pulse(6);
    pulse(5);
    wait_for(4'h0, PSQ_POWERDOWN);
    exp(4'h2, 32'h0);
    exp(4'h6, 32'h1);
    idle(40);
    exp(4'h0, PSQ_POWERDOWN);
    wake = 1'b0;
    rng = xs(rng);
    lag = rng[7:4];
    idle(12 + rng[3:0]);
    wake = 1'b1;
    wait_for(4'h0, PSQ_ACTIVE);
    exp(4'h6, 32'h0);
    kickOn = 1'b0;
    for (int i = 2; i >= 0; i--) begin
      wait_for(4'h4, i);
      exp(4'hA, 32'h1);
      wait_for(4'h0, PSQ_POWERDOWN);
      if (i > 0) wait_for(4'h0, PSQ_PU_CORE);
    end
    exp(4'h5, 32'h1);
    idle(50);
    exp(4'h0, PSQ_POWERDOWN);
    wake = 1'b0;
    wait_for(4'h5, 32'h0);
    exp(4'h4, 32'h3);
    wake = 1'b1;
    idle(8);
    exp(4'h0, PSQ_POWERDOWN);
    wait_for(4'h4, 32'h2);
    exp(4'hB, 32'h0);
    kickOn = 1'b1;
    wait_for(4'h0, PSQ_ACTIVE);
    exp(4'hB, 32'h1);
    warn = 1'b1;
    idle(8);
    exp(4'h7, 32'h1);
    exp(4'hC, 32'h1);
    sw.tempWarnMask = 1'b0;
    idle(3);
    exp(4'h7, 32'h0);
    warn = 1'b0;
    sw.otherEvent = 1'b1;
    pulse(3);
    idle(4);
    exp(4'h7, 32'h0);
    exp(4'hC, 32'h0);
    sw.otherEvent = 1'b0;
    idle(4);
    exp(4'h7, 32'h1);
    crit = 1'b1;
    idle(6);
    exp(4'h8, 32'h1);
    wait_for(4'h0, PSQ_RESET);
    exp(4'h1, 32'h0);
    exp(4'h4, 32'h3);
    idle(30);
    exp(4'h0, PSQ_RESET);
    exp(4'h8, 32'h1);
    crit = 1'b0;
    wait_for(4'h0, PSQ_ACTIVE);
    pulse(1);
    idle(2);
    exp(4'h8, 32'h0);
    por = 1'b1;
    idle(6);
    exp(4'h9, 32'h0);
    exp(4'h0, PSQ_RESET);
    exp(4'h1, 32'h0);
    por = 1'b0;
    wait_for(4'h0, PSQ_ACTIVE);
    exp(4'h9, 32'h1);
    idle(2);
    summarize();
  end
endmodule : psq_sequencer_tb
